// [rtl/sld_lcd_top.sv]
// Purpose: Register file and display control of the segment LCD driver.
// Assumes: sleep_power_mode comes from power logic on the same clock.
// Notes:   Read data appears one cycle after the read strobe.
// Summary of operation
// - Enable bit seven runs the driver; cleared, all drive lines idle.
// - While clear bit six is set, every display data register reads zero.
// - Blink enable bit five applies blinking from the clock register fields.
// - Sleep force-off bit four blanks the panel in sleep regardless of enable.
// - Bias bit low ties ladder node a to node b; high gives third bias.
// - Two commons: both shared pins serve as segment lines.
// - Three commons: second-common pin is a common, third-common pin a segment.
// - Four commons: both shared pins are commons.
// - Drives seventeen frontplanes by up to four commons.
// - Driver keeps working in every power mode, subject to sleep override.
// - A shared pin takes its LCD role only when its enable bit is set.
// - While hold is set, frames ignore data registers; new data next frame.
// - Update-finished flag sets when memory is taken up at frame start.
// - Blink source: software off, software on, fixed 2 Hz, or rate field.
`timescale 1ns/1ps
module sld_lcd_top #(
    parameter int unsigned DIV_CYCLES = sld_pkg::LCD_DIV_CYCLES
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic [7:0]                sfr_addr,
    input  wire logic                      sfr_wr_en,
    input  wire logic                      sfr_rd_en,
    input  wire logic [7:0]                sfr_wdata,
    output logic      [7:0]                sfr_rdata,
    input  wire logic                      sleep_power_mode,
    output logic      [3:0]                com_level,
    output logic      [sld_pkg::FP_COUNT-1:0] fp_level,
    output logic      [1:0]                shared_is_common,
    output logic      [1:0]                shared_lcd_sel,
    output logic      [7:0]                seg_enable_low,
    output logic      [7:0]                seg_enable_high,
    output logic                           ladder_tie,
    output logic                           ladder_external,
    output logic                           lcd_active
);
    import sld_pkg::*;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction : hit

    logic [7:0] main_cfg, clk_cfg, ladder_cfg, mem_ptr, frame_cfg;
    logic [7:0] next_main_cfg, next_clk_cfg, next_seg_low, next_seg_high;
    logic [7:0] next_ladder_cfg, next_mem_ptr, next_frame_cfg;
    logic       update_flag, next_update_flag, flag_set;
    logic [7:0] mem       [FP_COUNT];
    logic [7:0] next_mem  [FP_COUNT];
    logic [3:0] shadow      [FP_COUNT];
    logic [3:0] next_shadow [FP_COUNT];
    logic [7:0] next_rdata;
    logic [3:0] next_com_level;
    logic [FP_COUNT-1:0] next_fp_level;
    logic [1:0] blink_mode;
    logic       visible;

    sld_timing_if tm_bus ();

    sld_timing #(.DIV_CYCLES(DIV_CYCLES)) u_timing (
        .clk (clk),
        .rst (rst),
        .tm  (tm_bus.timer)
    );

    assign lcd_active = main_cfg[MAIN_EN_BIT] &&
                        !(sleep_power_mode && main_cfg[MAIN_SLEEP_BIT]);
    assign tm_bus.run = lcd_active;
    assign ladder_tie      = ~main_cfg[MAIN_BIAS_BIT];
    assign ladder_external = ladder_cfg[6];
    assign shared_is_common[0] = (main_cfg[1:0] == MUX_FOUR);
    assign shared_is_common[1] = main_cfg[1];
    assign shared_lcd_sel = {seg_enable_high[SEG_SECOND_BIT],
                             seg_enable_high[SEG_THIRD_BIT]};
    assign blink_mode = clk_cfg[CLK_MODE_LSB +: 2];

    // Reserved multiplex code 00 runs as two commons.
    always_comb begin
        case (main_cfg[MAIN_MUX_LSB +: 2])
            MUX_THREE: tm_bus.last_com = 2'h2;
            MUX_FOUR:  tm_bus.last_com = 2'h3;
            default:   tm_bus.last_com = 2'h1;
        endcase
        if (blink_mode == BLK_FIXED) begin
            tm_bus.blink_half = HALF_2HZ;
        end else begin
            case (clk_cfg[CLK_RATE_LSB +: 2])
                2'h0:    tm_bus.blink_half = HALF_1S;
                2'h1:    tm_bus.blink_half = HALF_2S;
                2'h2:    tm_bus.blink_half = HALF_3S;
                default: tm_bus.blink_half = HALF_4S;
            endcase
        end
    end

    // Configuration registers and the update-finished flag.
    assign flag_set = tm_bus.frame_start && !frame_cfg[FRAME_HOLD_BIT];
    always_comb begin
        next_main_cfg   = main_cfg;
        next_clk_cfg    = clk_cfg;
        next_seg_low    = seg_enable_low;
        next_seg_high   = seg_enable_high;
        next_ladder_cfg = ladder_cfg;
        next_mem_ptr    = mem_ptr;
        next_frame_cfg  = frame_cfg;
        next_update_flag = update_flag;
        if (sfr_wr_en) begin
            if (hit(sfr_addr, ADDR_MAIN)) begin
                next_main_cfg = sfr_wdata;
            end else if (hit(sfr_addr, ADDR_CLOCK)) begin
                next_clk_cfg = sfr_wdata;
            end else if (hit(sfr_addr, ADDR_SEG_LOW)) begin
                next_seg_low = sfr_wdata;
            end else if (hit(sfr_addr, ADDR_LADDER)) begin
                next_ladder_cfg = sfr_wdata & LADDER_MASK;
            end else if (hit(sfr_addr, ADDR_PTR)) begin
                next_mem_ptr = sfr_wdata;
            end else if (hit(sfr_addr, ADDR_FRAME)) begin
                next_frame_cfg = sfr_wdata & FRAME_MASK;
                if (!sfr_wdata[FRAME_FLAG_BIT]) begin
                    next_update_flag = 1'b0;
                end
            end else if (hit(sfr_addr, ADDR_SEG_HIGH)) begin
                next_seg_high = sfr_wdata;
            end
        end
        if (flag_set) begin
            next_update_flag = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            main_cfg        <= REG_RESET;
            clk_cfg         <= REG_RESET;
            seg_enable_low  <= REG_RESET;
            seg_enable_high <= REG_RESET;
            ladder_cfg      <= REG_RESET;
            mem_ptr         <= REG_RESET;
            frame_cfg       <= REG_RESET;
            update_flag     <= 1'b0;
        end else begin
            main_cfg        <= next_main_cfg;
            clk_cfg         <= next_clk_cfg;
            seg_enable_low  <= next_seg_low;
            seg_enable_high <= next_seg_high;
            ladder_cfg      <= next_ladder_cfg;
            mem_ptr         <= next_mem_ptr;
            frame_cfg       <= next_frame_cfg;
            update_flag     <= next_update_flag;
        end
    end

    // Display memory, and the frame copy that actually drives the pins.
    always_comb begin
        for (int i = 0; i < FP_COUNT; i++) begin
            next_mem[i]    = mem[i];
            next_shadow[i] = shadow[i];
            if (main_cfg[MAIN_CLR_BIT]) begin
                next_mem[i] = '0;
            end else if (sfr_wr_en && hit(sfr_addr, ADDR_DATA) && mem_ptr == 8'(i)) begin
                next_mem[i] = sfr_wdata;
            end
            if (flag_set) begin
                next_shadow[i] = mem[i][3:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < FP_COUNT; i++) begin
                mem[i]    <= '0;
                shadow[i] <= '0;
            end
        end else begin
            for (int i = 0; i < FP_COUNT; i++) begin
                mem[i]    <= next_mem[i];
                shadow[i] <= next_shadow[i];
            end
        end
    end

    // Pin levels and register read-back.
    always_comb begin
        visible = !main_cfg[MAIN_BLINK_BIT] || (blink_mode == BLK_SW_ON) ||
                  (blink_mode[1] && tm_bus.blink_phase);
        next_com_level = lcd_active ? (4'h1 << tm_bus.com_idx) : 4'h0;
        for (int i = 0; i < FP_COUNT; i++) begin
            next_fp_level[i] = lcd_active && visible && shadow[i][tm_bus.com_idx];
        end
        if (shared_is_common[0]) begin
            next_fp_level[PIN_THIRD] = lcd_active && (tm_bus.com_idx == 2'h3);
        end
        if (shared_is_common[1]) begin
            next_fp_level[PIN_SECOND] = lcd_active && (tm_bus.com_idx == 2'h2);
        end
        next_rdata = sfr_rdata;
        if (sfr_rd_en) begin
            if (hit(sfr_addr, ADDR_MAIN)) begin
                next_rdata = main_cfg;
            end else if (hit(sfr_addr, ADDR_CLOCK)) begin
                next_rdata = clk_cfg;
            end else if (hit(sfr_addr, ADDR_SEG_LOW)) begin
                next_rdata = seg_enable_low;
            end else if (hit(sfr_addr, ADDR_LADDER)) begin
                next_rdata = ladder_cfg;
            end else if (hit(sfr_addr, ADDR_PTR)) begin
                next_rdata = mem_ptr;
            end else if (hit(sfr_addr, ADDR_DATA)) begin
                next_rdata = (mem_ptr < 8'(FP_COUNT)) ? mem[mem_ptr[4:0]] : 8'h00;
            end else if (hit(sfr_addr, ADDR_FRAME)) begin
                next_rdata = frame_cfg | (8'(update_flag) << FRAME_FLAG_BIT);
            end else if (hit(sfr_addr, ADDR_SEG_HIGH)) begin
                next_rdata = seg_enable_high;
            end else begin
                next_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            com_level <= 4'h0;
            fp_level  <= '0;
            sfr_rdata <= 8'h00;
        end else begin
            com_level <= next_com_level;
            fp_level  <= next_fp_level;
            sfr_rdata <= next_rdata;
        end
    end

    // Helpers read only by the checks below.
    logic                  mem_zero;
    logic [4*FP_COUNT-1:0] shadow_flat;
    always_comb begin
        mem_zero = 1'b1;
        for (int i = 0; i < FP_COUNT; i++) begin
            mem_zero = mem_zero && (mem[i] == 8'h00);
            shadow_flat[4*i +: 4] = shadow[i];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_off_blank: assert property (!lcd_active |=> com_level == 4'h0 && fp_level == '0)
        else $error("Drive lines active while driver is off");
    a_clear_zero: assert property (main_cfg[MAIN_CLR_BIT] |=> mem_zero)
        else $error("Display data not cleared");
    a_sleep_off: assert property (sleep_power_mode && main_cfg[MAIN_SLEEP_BIT] |=>
        com_level == 4'h0) else $error("Commons driven in sleep with force-off set");
    a_bias_tie: assert property (sfr_wr_en && sfr_addr == ADDR_MAIN
                                 |=> ladder_tie == !$past(sfr_wdata[MAIN_BIAS_BIT]))
        else $error("Ladder tie does not follow bias");
    a_mux_two: assert property (sfr_wr_en && sfr_addr == ADDR_MAIN && sfr_wdata[1:0] == MUX_TWO
                                |=> shared_is_common == 2'h0)
        else $error("Shared pins not segments in two-common mode");
    a_mux_three: assert property (sfr_wr_en && sfr_addr == ADDR_MAIN && sfr_wdata[1:0] == MUX_THREE
                                  |=> shared_is_common == 2'h2)
        else $error("Wrong shared pin roles in three-common mode");
    a_mux_four: assert property (sfr_wr_en && sfr_addr == ADDR_MAIN && sfr_wdata[1:0] == MUX_FOUR
                                 |=> shared_is_common == 2'h3)
        else $error("Shared pins not commons in four-common mode");
    a_second_com: assert property (shared_is_common[1] |=>
        fp_level[PIN_SECOND] == com_level[2])
        else $error("Second-common pin not driving common two");
    a_third_com: assert property (shared_is_common[0] |=>
        fp_level[PIN_THIRD] == com_level[3])
        else $error("Third-common pin not driving common three");
    a_com_onehot: assert property (lcd_active |=> $onehot(com_level))
        else $error("Commons not one-hot while running");
    a_shared_sel: assert property (sfr_wr_en && sfr_addr == ADDR_SEG_HIGH |=>
        shared_lcd_sel == {$past(sfr_wdata[SEG_SECOND_BIT]), $past(sfr_wdata[SEG_THIRD_BIT])})
        else $error("Shared pin selection does not follow enable bits");
    a_hold_keep: assert property (frame_cfg[FRAME_HOLD_BIT] |=> $stable(shadow_flat))
        else $error("Frame data taken while hold is set");
    a_flag_set: assert property (tm_bus.frame_start && !frame_cfg[FRAME_HOLD_BIT] |=> update_flag)
        else $error("Update flag not set at frame start");
    a_blink_dark: assert property (lcd_active && main_cfg[MAIN_BLINK_BIT]
                                   && blink_mode == BLK_SW_OFF |=> fp_level[PIN_THIRD-1:0] == '0)
        else $error("Segments lit in software blink-off phase");

    c_frame: cover property (tm_bus.frame_start);
    c_flag: cover property (update_flag && lcd_active);
    c_blink: cover property (lcd_active && $changed(tm_bus.blink_phase));
    c_four: cover property (lcd_active && shared_is_common == 2'h3 && com_level[3]);
endmodule : sld_lcd_top

// [rtl/sld_pkg.sv]
// Purpose: Shared constants for the segment LCD driver configuration block.
// Assumes: Eight-bit special-function register bus of the embedded core.
// Notes:   All configuration registers reset to zero.
package sld_pkg;
    localparam logic [7:0] ADDR_MAIN     = 8'h95;
    localparam logic [7:0] ADDR_CLOCK    = 8'h96;
    localparam logic [7:0] ADDR_SEG_LOW  = 8'h97;
    localparam logic [7:0] ADDR_LADDER   = 8'h9C;
    localparam logic [7:0] ADDR_PTR      = 8'hAC;
    localparam logic [7:0] ADDR_DATA     = 8'hAE;
    localparam logic [7:0] ADDR_FRAME    = 8'hB1;
    localparam logic [7:0] ADDR_SEG_HIGH = 8'hED;

    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam logic [7:0] LADDER_MASK   = 8'h40;
    localparam logic [7:0] FRAME_MASK    = 8'h41;

    localparam int MAIN_EN_BIT    = 7;
    localparam int MAIN_CLR_BIT   = 6;
    localparam int MAIN_BLINK_BIT = 5;
    localparam int MAIN_SLEEP_BIT = 4;
    localparam int MAIN_BIAS_BIT  = 2;
    localparam int MAIN_MUX_LSB   = 0;
    localparam int CLK_MODE_LSB   = 6;
    localparam int CLK_RATE_LSB   = 4;
    localparam int FRAME_HOLD_BIT = 0;
    localparam int FRAME_FLAG_BIT = 1;
    localparam int SEG_THIRD_BIT  = 3;
    localparam int SEG_SECOND_BIT = 4;

    localparam logic [1:0] MUX_TWO   = 2'h1;
    localparam logic [1:0] MUX_THREE = 2'h2;
    localparam logic [1:0] MUX_FOUR  = 2'h3;
    localparam logic [1:0] BLK_SW_OFF = 2'h0;
    localparam logic [1:0] BLK_SW_ON  = 2'h1;
    localparam logic [1:0] BLK_FIXED  = 2'h2;

    localparam int FP_COUNT   = 17;
    localparam int PIN_THIRD  = 15;
    localparam int PIN_SECOND = 16;

    localparam int CLK_HZ         = 250_000_000;
    localparam int LCD_CLK_HZ     = 2048;
    localparam int LCD_DIV_CYCLES = CLK_HZ / LCD_CLK_HZ;
    localparam int DIV_W          = 17;
    localparam int BLINK_W        = 13;
    // Half blink periods in LCD clock ticks.
    localparam logic [BLINK_W-1:0] HALF_2HZ = BLINK_W'(LCD_CLK_HZ / 4);
    localparam logic [BLINK_W-1:0] HALF_1S  = BLINK_W'(LCD_CLK_HZ / 2);
    localparam logic [BLINK_W-1:0] HALF_2S  = BLINK_W'(LCD_CLK_HZ);
    localparam logic [BLINK_W-1:0] HALF_3S  = BLINK_W'(LCD_CLK_HZ * 3 / 2);
    localparam logic [BLINK_W-1:0] HALF_4S  = BLINK_W'(LCD_CLK_HZ * 2);
endpackage : sld_pkg

// [rtl/sld_timing.sv]
// Purpose: LCD clock divider, common sequencer and blink phase generator.
// Assumes: run low holds every counter at zero.
// Notes:   tick and frame_start are single-cycle enables.
`timescale 1ns/1ps
module sld_timing #(
    parameter int unsigned DIV_CYCLES = sld_pkg::LCD_DIV_CYCLES
) (
    input  wire logic     clk,
    input  wire logic     rst,
    sld_timing_if.timer   tm
);
    import sld_pkg::*;

    logic [DIV_W-1:0]   div_cnt,   next_div_cnt;
    logic [1:0]         com_q,     next_com_q;
    logic [BLINK_W-1:0] blink_cnt, next_blink_cnt;
    logic               phase_q,   next_phase_q;

    assign tm.tick        = tm.run && (div_cnt == DIV_W'(DIV_CYCLES - 1));
    assign tm.frame_start = tm.tick && (com_q == tm.last_com);
    assign tm.com_idx     = com_q;
    assign tm.blink_phase = phase_q;

    always_comb begin
        next_div_cnt   = '0;
        next_com_q     = '0;
        next_blink_cnt = '0;
        next_phase_q   = 1'b0;
        if (tm.run) begin
            next_div_cnt   = tm.tick ? '0 : div_cnt + 1'b1;
            next_com_q     = com_q;
            next_blink_cnt = blink_cnt;
            next_phase_q   = phase_q;
            if (tm.tick) begin
                next_com_q = (com_q == tm.last_com) ? 2'h0 : com_q + 2'h1;
                if (blink_cnt >= tm.blink_half - 1'b1) begin
                    next_blink_cnt = '0;
                    next_phase_q   = ~phase_q;
                end else begin
                    next_blink_cnt = blink_cnt + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt   <= '0;
            com_q     <= '0;
            blink_cnt <= '0;
            phase_q   <= 1'b0;
        end else begin
            div_cnt   <= next_div_cnt;
            com_q     <= next_com_q;
            blink_cnt <= next_blink_cnt;
            phase_q   <= next_phase_q;
        end
    end
endmodule : sld_timing

// [rtl/sld_timing_if.sv]
// Purpose: Carries frame and blink timing between control and timer.
// Assumes: Single clock domain.
// Notes:   None.
`timescale 1ns/1ps
interface sld_timing_if;
    logic                         run;
    logic [1:0]                   last_com;
    logic [sld_pkg::BLINK_W-1:0]  blink_half;
    logic                         tick;
    logic                         frame_start;
    logic [1:0]                   com_idx;
    logic                         blink_phase;
    modport timer (input run, last_com, blink_half,
                   output tick, frame_start, com_idx, blink_phase);
    modport ctrl  (output run, last_com, blink_half,
                   input tick, frame_start, com_idx, blink_phase);
endinterface : sld_timing_if

// [sim/sld_lcd_top_test.sv]
// Purpose: Self-checking bench for the segment LCD driver block.
// Assumes: Short LCD tick of four clocks; stimulus on falling edges.
// Notes:   Display contents are judged through the panel model.
`timescale 1ns/1ps
module sld_lcd_top_test;
    import sld_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, slp = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, seg_lo, seg_hi, v;
    logic [3:0] com;
    logic [16:0] fp;
    logic [1:0] shc, sel;
    logic tie, ext, act;
    logic [3:0][16:0] seen;
    int frames, n_mismatch = 0, cmp_count = 0;
    always #2 clk = ~clk;
    sld_lcd_top #(.DIV_CYCLES(4)) u_dut (.clk(clk), .rst(rst), .sfr_addr(addr),
        .sfr_wr_en(wr), .sfr_rd_en(rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
        .sleep_power_mode(slp), .com_level(com), .fp_level(fp), .shared_is_common(shc),
        .shared_lcd_sel(sel), .seg_enable_low(seg_lo), .seg_enable_high(seg_hi),
        .ladder_tie(tie), .ladder_external(ext), .lcd_active(act));
    sld_panel_model u_panel (.clk(clk), .com_level(com), .fp_level(fp), .seen(seen),
        .frames(frames));
    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic check(input string what, input logic [16:0] got, input logic [16:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
    endtask : wr_reg
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1;
        @(negedge clk);
        rd = 0;
        check("register", rdata, exp);
    endtask : chk_reg
    task automatic wait_frames(input int k);
        int f0;
        int t;
        f0 = frames;
        t = 0;
        while (frames < f0 + k && t < 2000) begin
            @(negedge clk);
            t++;
        end
        if (t >= 2000) begin
            n_mismatch++;
            $display("Error frame wait timed out");
            stop_test();
        end
    endtask : wait_frames
    task automatic t_regs();
        logic [7:0] ta [5] = '{ADDR_CLOCK, ADDR_SEG_LOW, ADDR_SEG_HIGH, ADDR_LADDER, ADDR_FRAME};
        logic [7:0] td [5] = '{8'hF5, 8'hA5, 8'h18, 8'hFF, 8'hC2};
        logic [7:0] te [5] = '{8'hF5, 8'hA5, 8'h18, 8'h40, 8'h40};
        check("ladder_tie", tie, 1'b1);
        for (int i = 0; i < 5; i++) chk_reg(ta[i], 8'h00);
        wr_reg(8'h90, 8'hFF);
        chk_reg(8'h90, 8'h00);
        for (int i = 0; i < 5; i++) wr_reg(ta[i], td[i]);
        for (int i = 0; i < 5; i++) chk_reg(ta[i], te[i]);
        check("shared_lcd_sel", sel, 2'b11);
        check("seg_enable_low", seg_lo, 8'hA5);
        check("seg_enable_high", seg_hi, 8'h18);
        check("ladder_external", ext, 1'b1);
        wr_reg(ADDR_CLOCK, 8'h00);
        wr_reg(ADDR_FRAME, 8'h00);
    endtask : t_regs
    task automatic t_mux();
        logic [1:0] sc [3] = '{2'b00, 2'b10, 2'b11};
        for (int m = 1; m < 4; m++) begin
            wr_reg(ADDR_MAIN, 8'(m) | (m == 3 ? 8'h04 : 8'h00));
            check("shared_is_common", shc, sc[m-1]);
            check("ladder_tie", tie, m != 3);
            chk_reg(ADDR_MAIN, 8'(m) | (m == 3 ? 8'h04 : 8'h00));
        end
    endtask : t_mux
    task automatic t_power();
        wr_reg(ADDR_MAIN, 8'h83);
        check("lcd_active", act, 1'b1);
        slp = 1;
        @(negedge clk);
        check("lcd_active", act, 1'b1);
        wr_reg(ADDR_MAIN, 8'h93);
        check("lcd_active", act, 1'b0);
        @(negedge clk);
        check("com_level", com, 4'h0);
        slp = 0;
        @(negedge clk);
        check("lcd_active", act, 1'b1);
        wr_reg(ADDR_MAIN, 8'h03);
        @(negedge clk);
        check("com_level", com, 4'h0);
    endtask : t_power
    task automatic t_display();
        wr_reg(ADDR_PTR, 8'd14);
        wr_reg(ADDR_DATA, 8'h0A);
        wr_reg(ADDR_PTR, 8'd0);
        wr_reg(ADDR_DATA, 8'h05);
        wr_reg(ADDR_MAIN, 8'h83);
        wait_frames(3);
        for (int n = 0; n < 4; n++) begin
            check("row seg0", seen[n][0], (4'h5 >> n) & 1);
            check("row seg14", seen[n][14], (4'hA >> n) & 1);
        end
        check("third pin com3", seen[3][15], 1'b1);
        check("third pin com0", seen[0][15], 1'b0);
        check("second pin com2", seen[2][16], 1'b1);
        chk_reg(ADDR_FRAME, 8'h02);
        wr_reg(ADDR_FRAME, 8'h01);
        wr_reg(ADDR_DATA, 8'h0A);
        wait_frames(3);
        check("held seg0", seen[0][0], 1'b1);
        wr_reg(ADDR_FRAME, 8'h00);
        wait_frames(3);
        check("new seg0 c0", seen[0][0], 1'b0);
        check("new seg0 c1", seen[1][0], 1'b1);
        wr_reg(ADDR_MAIN, 8'hC3);
        chk_reg(ADDR_DATA, 8'h00);
        wr_reg(ADDR_DATA, 8'h07);
        chk_reg(ADDR_DATA, 8'h00);
        wr_reg(ADDR_MAIN, 8'h83);
        wait_frames(3);
        check("cleared seg0", seen[1][0], 1'b0);
    endtask : t_display
    task automatic t_blink();
        int dark;
        wr_reg(ADDR_DATA, 8'h01);
        wr_reg(ADDR_MAIN, 8'hA3);
        wait_frames(3);
        check("blink sw off", seen[0][0], 1'b0);
        wr_reg(ADDR_CLOCK, 8'h40);
        wait_frames(3);
        check("blink sw on", seen[0][0], 1'b1);
        wr_reg(ADDR_CLOCK, 8'h80);
        dark = 0;
        for (int i = 0; i < 256; i++) begin
            wait_frames(1);
            if (seen[0][0] === 1'b0) dark++;
        end
        // Half of a 2 Hz period is 512 ticks, i.e. 128 four-common frames.
        check("blink 2 Hz", dark >= 120 && dark <= 136, 1'b1);
    endtask : t_blink
    task automatic t_shared();
        wr_reg(ADDR_PTR, 8'd16);
        wr_reg(ADDR_DATA, 8'h02);
        wr_reg(ADDR_MAIN, 8'h81);
        wait_frames(3);
        check("two seg pin c0", seen[0][16], 1'b0);
        check("two seg pin c1", seen[1][16], 1'b1);
        wr_reg(ADDR_MAIN, 8'h82);
        wait_frames(3);
        check("three com pin c1", seen[1][16], 1'b0);
        check("three com pin c2", seen[2][16], 1'b1);
        check("three seg pin c2", seen[2][15], 1'b0);
    endtask : t_shared
    initial begin
        repeat (16) @(negedge clk);
        rst = 0;
        t_regs();
        t_mux();
        t_power();
        t_display();
        t_blink();
        t_shared();
        stop_test();
    end
endmodule : sld_lcd_top_test

// [sim/sld_panel_model.sv]
// Purpose: Panel model that latches the segment row of each common.
// Assumes: One-hot common drive and registered segment levels.
// Notes:   A frame is counted at each entry to common zero.
`timescale 1ns/1ps
module sld_panel_model (
    input  wire logic        clk,
    input  wire logic [3:0]  com_level,
    input  wire logic [16:0] fp_level,
    output logic [3:0][16:0] seen,
    output int               frames
);
    logic [3:0] last_com = 4'h0;
    initial frames = 0;
    // A glass cell only shows its row while its own common is driven.
    always @(posedge clk) begin
        for (int n = 0; n < 4; n++) begin
            if (com_level === 4'(1 << n)) begin
                seen[n] <= fp_level;
            end
        end
        if (com_level === 4'h1 && last_com !== 4'h1) begin
            frames <= frames + 1;
        end
        last_com <= com_level;
    end
endmodule : sld_panel_model
